//--- hdl/ctm_pkg.sv
/*
  Constants, types and register map of the compact timer.
  Assumes a single 50 MHz clock and a plain strobe register port.
*/
// Functional notes
// - Mode bits: 00 compare, 11 timer, 10 PWM.
// - Clear-select low: period match clears, both flags.
// - Clear-select high: compare-A clears, A flag only.
// - Compare-A zero: overflow at 3FF, no flag outside PWM.
// - Compare pin moves only on compare-A event or enable rise.
// - Action field: high, low, toggle or hold.
// - Enable rise loads pin initial level.
// - Timer mode counts like compare, pin released.
// - PWM ignores clear-select; period source clears.
// - Swap bit exchanges period and duty sources.
// - Period code gives 128 steps, zero 1024.
// - Swapped: compare-A period, code gives duty.
// - Duty at least period means always active.
// - PWM raises both flags on matches.
// - Level bit sets polarity; action enables/forces.
// - Invert bit inverts PWM pin waveform.
// - PWM counting continues while pin forced.
// - Level bit: PWM active level, compare init.
package ctm_pkg;

  localparam int unsigned CTM_CNT_W  = 10;
  localparam int unsigned CTM_PER_W  = 3;
  localparam int unsigned CTM_LOW_W  = CTM_CNT_W - CTM_PER_W;
  localparam int unsigned CTM_ADDR_W = 8;
  localparam int unsigned CTM_DATA_W = 16;
  localparam int unsigned CTM_C1_W   = 8;

  localparam logic [CTM_CNT_W-1:0] CTM_CNT_MAX  = 10'h3FF;
  localparam logic [CTM_CNT_W-1:0] CTM_CNT_ZERO = 10'h000;
  localparam logic [CTM_PER_W-1:0] CTM_PER_ZERO = 3'h0;

  // Register byte offsets.
  localparam logic [CTM_ADDR_W-1:0] CTM_OFF_CTRL0 = 8'h00;
  localparam logic [CTM_ADDR_W-1:0] CTM_OFF_CTRL1 = 8'h04;
  localparam logic [CTM_ADDR_W-1:0] CTM_OFF_CMPA  = 8'h08;
  localparam logic [CTM_ADDR_W-1:0] CTM_OFF_FLAGS = 8'h0C;
  localparam logic [CTM_ADDR_W-1:0] CTM_OFF_COUNT = 8'h10;

  // Field positions.
  localparam int unsigned CTM_C0_EN_BIT  = 0;
  localparam int unsigned CTM_C0_PER_LSB = 1;
  localparam int unsigned CTM_FLG_A_BIT  = 0;
  localparam int unsigned CTM_FLG_P_BIT  = 1;

  typedef enum logic [1:0] {
    CTM_MODE_CMP  = 2'b00,
    CTM_MODE_RSVD = 2'b01,
    CTM_MODE_PWM  = 2'b10,
    CTM_MODE_TMR  = 2'b11
  } ctm_mode_e;

  // Output action codes in compare mode.
  localparam logic [1:0] CTM_CMP_HOLD = 2'h0;
  localparam logic [1:0] CTM_CMP_LOW  = 2'h1;
  localparam logic [1:0] CTM_CMP_HIGH = 2'h2;
  localparam logic [1:0] CTM_CMP_TOG  = 2'h3;
  // Output action codes in PWM mode; other codes drive the waveform.
  localparam logic [1:0] CTM_PWM_FLO  = 2'h0;
  localparam logic [1:0] CTM_PWM_FHI  = 2'h1;

  typedef struct packed {
    ctm_mode_e  mode;
    logic [1:0] output_action;
    logic       output_level_control;
    logic       output_invert;
    logic       period_duty_swap;
    logic       clear_source_select;
  } ctm_ctrl_s;

  localparam ctm_ctrl_s CTM_CTRL_RST = 8'h00;

endpackage

//--- hdl/ctm_cmp.sv
/*
  Comparator stage: compare-A and period matches and the PWM duty test.
  Assumes the caller clears the counter on the match it selects.
*/
`timescale 1ns/100ps
module ctm_cmp #(
  parameter int unsigned CNT_W = ctm_pkg::CTM_CNT_W,
  parameter int unsigned PER_W = ctm_pkg::CTM_PER_W
) (
  // Counter and compare values.
  input  wire logic [CNT_W-1:0] count,
  input  wire logic [CNT_W-1:0] compare_a_value,
  input  wire logic [PER_W-1:0] period_compare_value,
  input  wire logic             period_duty_swap,
  // Match results.
  output      logic             a_hit,
  output      logic             p_hit,
  output      logic             pwm_active
);
  localparam int unsigned LOW_W = CNT_W - PER_W;

  logic [CNT_W-1:0] count_inc;
  logic [CNT_W:0]   duty_val;

  // Matches are taken on the next count so a clear lands on the boundary.
  assign count_inc = CNT_W'(count + 1'b1);
  assign a_hit     = (count_inc == compare_a_value);
  // top three bits, overflow for zero
  assign p_hit     = (count_inc[CNT_W-1 -: PER_W] == period_compare_value) &&
                     (count_inc[LOW_W-1:0] == '0);

  always_comb begin
    if (period_duty_swap) begin
      duty_val = {(period_compare_value == '0), period_compare_value, {LOW_W{1'b0}}};
    end else begin
      duty_val = {1'b0, compare_a_value};
    end
  end

  assign pwm_active = ({1'b0, count} < duty_val);

endmodule // ctm_cmp

//--- hdl/ctm_top.sv
/*
  Compact timer: 10-bit counter, compare, timer and edge-aligned PWM modes.
  Assumes a master that issues one-cycle read or write strobes.
*/
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module ctm_top #(
  parameter int unsigned CNT_W  = ctm_pkg::CTM_CNT_W,
  parameter int unsigned PER_W  = ctm_pkg::CTM_PER_W,
  parameter int unsigned ADDR_W = ctm_pkg::CTM_ADDR_W,
  parameter int unsigned DATA_W = ctm_pkg::CTM_DATA_W
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Register port.
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output      logic [DATA_W-1:0] bus_rdata,
  // Timer output pin.
  output      logic              tm_pin_out,
  output      logic              tm_pin_oe
);

  logic                  rst_meta_reg;
  logic                  rst_sync_b_reg;
  logic                  enable_reg;
  logic                  en_prev_reg;
  logic [PER_W-1:0]      period_reg;
  ctm_pkg::ctm_ctrl_s    ctrl_reg;
  logic [CNT_W-1:0]      cmpa_reg;
  logic [CNT_W-1:0]      count_reg;
  logic                  a_flag_reg;
  logic                  p_flag_reg;
  logic                  cmp_pin_reg;
  logic                  pin_out_reg;
  logic                  pin_oe_reg;
  logic [DATA_W-1:0]     rdata_reg;
  logic [DATA_W-1:0]     rdata_next;
  logic                  pin_out_next;
  logic                  pin_oe_next;
  logic                  a_hit;
  logic                  p_hit;
  logic                  pwm_active;
  logic                  en_rise;
  logic                  run;
  logic                  is_pwm;
  logic                  clr_on_a;
  logic                  clr_hit;
  logic                  a_evt;
  logic                  p_evt;
  logic                  pwm_lvl;
  logic                  wr_ctrl0;
  logic                  wr_ctrl1;
  logic                  wr_cmpa;
  logic                  wr_flags;

  // Reset is applied at once and released through two flip-flops.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg   <= 1'b0;
      rst_sync_b_reg <= 1'b0;
    end else begin
      rst_meta_reg   <= 1'b1;
      rst_sync_b_reg <= rst_meta_reg;
    end
  end

  assign wr_ctrl0 = bus_wr && (bus_addr == ctm_pkg::CTM_OFF_CTRL0);
  assign wr_ctrl1 = bus_wr && (bus_addr == ctm_pkg::CTM_OFF_CTRL1);
  assign wr_cmpa  = bus_wr && (bus_addr == ctm_pkg::CTM_OFF_CMPA);
  assign wr_flags = bus_wr && (bus_addr == ctm_pkg::CTM_OFF_FLAGS);

  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      enable_reg <= 1'b0;
      period_reg <= ctm_pkg::CTM_PER_ZERO;
    end else if (wr_ctrl0) begin
      enable_reg <= bus_wdata[ctm_pkg::CTM_C0_EN_BIT];
      period_reg <= bus_wdata[ctm_pkg::CTM_C0_PER_LSB +: PER_W];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      ctrl_reg <= ctm_pkg::CTM_CTRL_RST;
    end else if (wr_ctrl1) begin
      ctrl_reg <= ctm_pkg::ctm_ctrl_s'(bus_wdata[ctm_pkg::CTM_C1_W-1:0]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      cmpa_reg <= ctm_pkg::CTM_CNT_ZERO;
    end else if (wr_cmpa) begin
      cmpa_reg <= bus_wdata[CNT_W-1:0];
    end
  end

  ctm_cmp #(
    .CNT_W (CNT_W),
    .PER_W (PER_W)
  ) u_cmp (
    .count                (count_reg),
    .compare_a_value      (cmpa_reg),
    .period_compare_value (period_reg),
    .period_duty_swap     (ctrl_reg.period_duty_swap),
    .a_hit                (a_hit),
    .p_hit                (p_hit),
    .pwm_active           (pwm_active)
  );

  // Counting starts in the cycle after the enable rise.
  assign en_rise = enable_reg && !en_prev_reg;
  assign run     = enable_reg && en_prev_reg;
  assign is_pwm  = (ctrl_reg.mode == ctm_pkg::CTM_MODE_PWM);

  assign clr_on_a = is_pwm ? ctrl_reg.period_duty_swap : ctrl_reg.clear_source_select;
  assign clr_hit  = clr_on_a ? a_hit : p_hit;

  // compare-A event, zero value silent outside PWM
  assign a_evt = run && a_hit && (is_pwm || (cmpa_reg != ctm_pkg::CTM_CNT_ZERO));
  assign p_evt = run && p_hit && (is_pwm || !ctrl_reg.clear_source_select);

  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      en_prev_reg <= 1'b0;
    end else begin
      en_prev_reg <= enable_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      count_reg <= ctm_pkg::CTM_CNT_ZERO;
    end else if (en_rise) begin
      count_reg <= ctm_pkg::CTM_CNT_ZERO;
    end else if (run) begin
      count_reg <= clr_hit ? ctm_pkg::CTM_CNT_ZERO : CNT_W'(count_reg + 1'b1);
    end
  end

  // Hardware set wins over a software write-one clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      a_flag_reg <= 1'b0;
    end else if (a_evt) begin
      a_flag_reg <= 1'b1;
    end else if (wr_flags && bus_wdata[ctm_pkg::CTM_FLG_A_BIT]) begin
      a_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      p_flag_reg <= 1'b0;
    end else if (p_evt) begin
      p_flag_reg <= 1'b1;
    end else if (wr_flags && bus_wdata[ctm_pkg::CTM_FLG_P_BIT]) begin
      p_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      cmp_pin_reg <= 1'b0;
    end else if (en_rise) begin
      cmp_pin_reg <= ctrl_reg.output_level_control;
    end else if (a_evt && (ctrl_reg.mode == ctm_pkg::CTM_MODE_CMP)) begin
      case (ctrl_reg.output_action)
        ctm_pkg::CTM_CMP_LOW:  cmp_pin_reg <= 1'b0;
        ctm_pkg::CTM_CMP_HIGH: cmp_pin_reg <= 1'b1;
        ctm_pkg::CTM_CMP_TOG:  cmp_pin_reg <= !cmp_pin_reg;
        default:               cmp_pin_reg <= cmp_pin_reg;
      endcase
    end
  end

  // level bit picks the active level
  assign pwm_lvl = pwm_active ? ctrl_reg.output_level_control
                              : !ctrl_reg.output_level_control;

  always_comb begin
    pin_out_next = 1'b0;
    pin_oe_next  = 1'b0;
    case (ctrl_reg.mode)
      ctm_pkg::CTM_MODE_CMP: begin
        pin_out_next = cmp_pin_reg ^ ctrl_reg.output_invert;
        pin_oe_next  = 1'b1;
      end
      ctm_pkg::CTM_MODE_PWM: begin
        pin_oe_next = 1'b1;
        case (ctrl_reg.output_action)
          ctm_pkg::CTM_PWM_FLO: pin_out_next = 1'b0;
          ctm_pkg::CTM_PWM_FHI: pin_out_next = 1'b1;
          default:              pin_out_next = pwm_lvl ^ ctrl_reg.output_invert;
        endcase
      end
      // timer mode leaves the pin free
      default: begin
        pin_out_next = 1'b0;
        pin_oe_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg  <= 1'b0;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
    end
  end

  always_comb begin
    rdata_next = '0;
    if (bus_rd) begin
      case (bus_addr)
        ctm_pkg::CTM_OFF_CTRL0: rdata_next = DATA_W'({period_reg, enable_reg});
        ctm_pkg::CTM_OFF_CTRL1: rdata_next = DATA_W'(ctrl_reg);
        ctm_pkg::CTM_OFF_CMPA:  rdata_next = DATA_W'(cmpa_reg);
        ctm_pkg::CTM_OFF_FLAGS: rdata_next = DATA_W'({p_flag_reg, a_flag_reg});
        ctm_pkg::CTM_OFF_COUNT: rdata_next = DATA_W'(count_reg);
        default:                rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata  = rdata_reg;
  assign tm_pin_out = pin_out_reg;
  assign tm_pin_oe  = pin_oe_reg;

  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_b_reg);

  a_enable_restart: assert property (
    en_rise |=> (count_reg == ctm_pkg::CTM_CNT_ZERO) ##1
                (!enable_reg || count_reg == 10'h001 || clr_hit))
    else $error("counter did not restart from zero on enable rise");

  a_count_step: assert property (
    (run && !clr_hit) |=> (count_reg == CNT_W'($past(count_reg) + 1'b1)))
    else $error("counter did not advance by one");

  a_pwm_period_clr: assert property (
    (run && is_pwm && !ctrl_reg.period_duty_swap && p_hit) |=>
    (count_reg == ctm_pkg::CTM_CNT_ZERO))
    else $error("PWM period match did not clear the counter");

  a_init_level: assert property (
    en_rise |=> (cmp_pin_reg == $past(ctrl_reg.output_level_control)))
    else $error("pin not loaded with initial level");

  a_no_pflag_csel: assert property (
    (run && !is_pwm && ctrl_reg.clear_source_select && p_hit && !p_flag_reg) |=>
    !p_flag_reg)
    else $error("period flag set while compare-A clears");

  a_zero_cmpa_wrap: assert property (
    (run && !is_pwm && ctrl_reg.clear_source_select && a_hit && !a_flag_reg &&
     cmpa_reg == ctm_pkg::CTM_CNT_ZERO) |->
    (count_reg == ctm_pkg::CTM_CNT_MAX) ##1
    (count_reg == ctm_pkg::CTM_CNT_ZERO && !a_flag_reg))
    else $error("zero compare-A did not overflow silently");

  a_flag_a_set: assert property (
    a_evt |=> a_flag_reg [*2] or (a_flag_reg ##1 (wr_flags || !a_flag_reg)))
    else $error("compare-A flag not raised");

  a_timer_pin_free: assert property (
    (ctrl_reg.mode == ctm_pkg::CTM_MODE_TMR) |=> !tm_pin_oe)
    else $error("timer mode drove the pin");

  a_cmp_hold_pin: assert property (
    (ctrl_reg.mode == ctm_pkg::CTM_MODE_CMP && !en_rise &&
     ctrl_reg.output_action == ctm_pkg::CTM_CMP_HOLD) |=> $stable(cmp_pin_reg))
    else $error("pin changed with hold action");

  c_enable_rise: cover property (en_rise ##1 run);
  c_pwm_a_event: cover property (is_pwm && a_evt);
  c_cmp_p_event: cover property (!is_pwm && p_evt);
  c_cmp_toggle:  cover property (
    ctrl_reg.output_action == ctm_pkg::CTM_CMP_TOG && a_evt ##1 $changed(cmp_pin_reg));

endmodule // ctm_top

//--- testbench/ctm_top_tb.sv
/*
  Self-checking bench for the compact timer: register port, compare, timer and PWM modes.
  Assumes the register map and offsets of the timer's package, one 50 MHz clock.
*/
`timescale 1ns/100ps
module ctm_top_tb;
  logic        clk_sys;
  logic        rst_b;
  logic [7:0]  bus_addr;
  logic [15:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [15:0] bus_rdata;
  logic        tm_pin_out;
  logic        tm_pin_oe;
  int          fail_count;
  int          checks_done;
  int          cycles;
  logic [15:0] rdv;
  // Pin seen as {driven, level}; a released pin reads as zero.
  wire logic [15:0] pin_view = {14'h0000, tm_pin_oe, tm_pin_oe & tm_pin_out};

  ctm_top i_dut (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .bus_addr  (bus_addr),
    .bus_wdata (bus_wdata),
    .bus_wr    (bus_wr),
    .bus_rd    (bus_rd),
    .bus_rdata (bus_rdata),
    .tm_pin_out(tm_pin_out),
    .tm_pin_oe (tm_pin_oe)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The whole run needs well under this many cycles.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count = fail_count + 1;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    @(negedge clk_sys);
    d = bus_rdata;
  endtask

  task automatic setup(input logic [7:0] c1, input logic [15:0] a, input logic [2:0] code);
    wr(ctm_pkg::CTM_OFF_CTRL0, 16'h0000);
    wr(ctm_pkg::CTM_OFF_CMPA, a);
    wr(ctm_pkg::CTM_OFF_CTRL1, {8'h00, c1});
    wr(ctm_pkg::CTM_OFF_FLAGS, 16'h0003);
    wr(ctm_pkg::CTM_OFF_CTRL0, {12'h000, code, 1'b1});
  endtask

  task automatic reg_test();
    rd(ctm_pkg::CTM_OFF_CTRL0, rdv);
    chk("ctrl0_rst", 16'h0000, rdv);
    rd(ctm_pkg::CTM_OFF_FLAGS, rdv);
    chk("flags_rst", 16'h0000, rdv);
    wr(ctm_pkg::CTM_OFF_CTRL1, 16'h00A5);
    rd(ctm_pkg::CTM_OFF_CTRL1, rdv);
    chk("ctrl1", 16'h00A5, rdv);
    // Read data stand for one cycle only and return to zero.
    @(negedge clk_sys);
    chk("rdata_idle", 16'h0000, bus_rdata);
    wr(ctm_pkg::CTM_OFF_CMPA, 16'hFFFF);
    rd(ctm_pkg::CTM_OFF_CMPA, rdv);
    chk("cmpa", 16'h03FF, rdv);
    wr(8'h14, 16'h0001);
    rd(8'h14, rdv);
    chk("unmapped", 16'h0000, rdv);
    wr(ctm_pkg::CTM_OFF_COUNT, 16'h0055);
    rd(ctm_pkg::CTM_OFF_COUNT, rdv);
    chk("count_ro", 16'h0000, rdv);
  endtask

  // Runs compare or timer mode and checks flags and pin at two moments.
  task automatic cmp_run(input logic [7:0] c1, input logic [15:0] a, input logic [2:0] code,
                         input logic [15:0] p0, input int w1, input logic [15:0] f1,
                         input logic [15:0] p1, input int w2, input logic [15:0] f2,
                         input logic [15:0] p2);
    setup(c1, a, code);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("pin_init", p0, pin_view);
    repeat (w1) @(posedge clk_sys);
    rd(ctm_pkg::CTM_OFF_FLAGS, rdv);
    chk("flags_1", f1, rdv);
    chk("pin_1", p1, pin_view);
    repeat (w2) @(posedge clk_sys);
    rd(ctm_pkg::CTM_OFF_FLAGS, rdv);
    chk("flags_2", f2, rdv);
    chk("pin_2", p2, pin_view);
  endtask

  // Counts high pin cycles over one whole PWM period.
  task automatic pwm_run(input logic [7:0] c1, input logic [15:0] a, input logic [2:0] code,
                         input int win, input int ones, input logic [15:0] f);
    int n;
    n = 0;
    setup(c1, a, code);
    repeat (20) @(posedge clk_sys);
    // The pin is looked at mid-cycle, where the registered level has settled.
    for (int i = 0; i < win; i++) begin
      @(negedge clk_sys);
      if (tm_pin_out === 1'b1) n++;
    end
    chk("pwm_ones", ones[15:0], n[15:0]);
    chk("pwm_oe", 16'h0001, {15'h0000, tm_pin_oe});
    rd(ctm_pkg::CTM_OFF_FLAGS, rdv);
    chk("pwm_flags", f, rdv);
  endtask

  initial begin
    rst_b       = 1'b0;
    bus_addr    = 8'h00;
    bus_wdata   = 16'h0000;
    bus_wr      = 1'b0;
    bus_rd      = 1'b0;
    fail_count  = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk_sys);
    reg_test();
    cmp_run(8'h30, 16'h0040, 3'h1, 16'h0002,
            80, 16'h0001, 16'h0003, 60, 16'h0003, 16'h0003);
    cmp_run(8'h21, 16'h00C8, 3'h1, 16'h0002,
            150, 16'h0000, 16'h0002, 60, 16'h0001, 16'h0003);
    cmp_run(8'h19, 16'h0000, 3'h1, 16'h0003,
            600, 16'h0000, 16'h0003, 500, 16'h0000, 16'h0003);
    cmp_run(8'h08, 16'h0040, 3'h1, 16'h0003,
            80, 16'h0001, 16'h0003, 60, 16'h0003, 16'h0003);
    cmp_run(8'h18, 16'h0040, 3'h1, 16'h0003,
            80, 16'h0001, 16'h0002, 60, 16'h0003, 16'h0002);
    cmp_run(8'h34, 16'h0040, 3'h1, 16'h0003,
            80, 16'h0001, 16'h0002, 60, 16'h0003, 16'h0002);
    cmp_run(8'hF8, 16'h0040, 3'h1, 16'h0000,
            80, 16'h0001, 16'h0000, 60, 16'h0003, 16'h0000);
    cmp_run(8'h78, 16'h0040, 3'h1, 16'h0000,
            80, 16'h0001, 16'h0000, 60, 16'h0003, 16'h0000);
    cmp_run(8'h30, 16'h0040, 3'h0, 16'h0002,
            80, 16'h0001, 16'h0003, 980, 16'h0003, 16'h0003);
    pwm_run(8'hA8, 16'h0020, 3'h1, 128, 32, 16'h0003);
    pwm_run(8'hAC, 16'h0020, 3'h1, 128, 96, 16'h0003);
    pwm_run(8'hA0, 16'h0020, 3'h1, 128, 96, 16'h0003);
    pwm_run(8'hA9, 16'h0020, 3'h1, 128, 32, 16'h0003);
    pwm_run(8'hA8, 16'h0064, 3'h3, 384, 100, 16'h0003);
    pwm_run(8'hA8, 16'h0200, 3'h0, 1024, 512, 16'h0003);
    pwm_run(8'hA8, 16'h00C8, 3'h1, 128, 128, 16'h0002);
    pwm_run(8'hAA, 16'h012C, 3'h1, 300, 128, 16'h0003);
    pwm_run(8'h88, 16'h0020, 3'h1, 128, 0, 16'h0003);
    pwm_run(8'h98, 16'h0020, 3'h1, 128, 128, 16'h0003);
    end_sim();
  end
endmodule // ctm_top_tb
